// file: src/mpf_pair.sv
`default_nettype none
// One duty generator driving a high/low output pair
module mpf_pair
  import mpf_pkg::*;
#(
  parameter int W = 16
)
(
  input wire logic [W-1:0] count,
  input wire logic [W-1:0] duty,
  input wire logic running,
  input wire logic compl_en,
  input wire logic [1:0] ovr_en,
  input wire logic [1:0] ovr_val,
  output logic [1:0] pins
);
  logic hi;
  // ****************************************
  // Duty compare and override
  // ****************************************
  always_comb
  begin
    hi = running && (count < duty);
    pins[1] = ovr_en[1] ? ovr_val[1] : hi;
    if (ovr_en[0])
    begin
      pins[0] = ovr_val[0];
    end
    else if (compl_en)
    begin
      pins[0] = ~pins[1];
    end
    else
    begin
      pins[0] = hi;
    end
  end
endmodule
`default_nettype wire

// file: src/mpf_pkg.sv
`default_nettype none
package mpf_pkg;
  // ****************************************
  // Register byte addresses (chosen map)
  // ****************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PERIOD = 8'h04;
  localparam logic [7:0] ADDR_DUTY1 = 8'h08;
  localparam logic [7:0] ADDR_DUTY2 = 8'h0c;
  localparam logic [7:0] ADDR_DUTY3 = 8'h10;
  localparam logic [7:0] ADDR_DUTY4 = 8'h14;
  localparam logic [7:0] ADDR_SEVT = 8'h18;
  localparam logic [7:0] ADDR_OVR = 8'h1c;
  localparam logic [7:0] ADDR_FLTA = 8'h20;
  localparam logic [7:0] ADDR_STAT = 8'h24;
  localparam logic [7:0] ADDR_MASK = 8'h28;
  localparam logic [7:0] ADDR_TBASE = 8'h2c;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_EN = 0;
  localparam int CTRL_CENTER = 1;
  localparam int CTRL_SINGLE = 2;
  localparam int CTRL_IMMED = 3;
  localparam int CTRL_COMPL_LO = 4;
  localparam int FLT_CYCLE_BIT = 7;
  localparam int FLT_STATE_LO = 8;
  localparam int NUM_PAIRS = 4;
  localparam int STAT_PERIOD = 0;
  localparam int STAT_SEVT = 1;
  localparam int STAT_CZERO = 2;
  localparam int STAT_FAULT = 3;
  localparam int NUM_EVENTS = 4;

  // Implemented bits of fault A control: 15..8, 7, 3..0
  localparam logic [15:0] FLTA_IMPL_MASK = 16'hff8f;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

  // Time base direction
  typedef enum logic {MPF_UP, MPF_DOWN} mpf_dir_t;

  // Software configuration carried to the core
  typedef struct packed {
    logic enable;
    logic center;
    logic single;
    logic immediate;
    logic [3:0] compl_en;
    logic [15:0] period;
    logic [15:0] sevt_cmp;
    logic [7:0] ovr_en;
    logic [7:0] ovr_val;
    logic [15:0] flta;
  } mpf_cfg_t;
endpackage
`default_nettype wire

// file: src/mpf_top.sv
`default_nettype none
// How it works
// - four duty generators, eight paired outputs
// - low pin inverts high when complementary
// - sixteen bit period and duty
// - edge or center aligned, software chosen
// - single pulse mode stops after one period
// - center mode raises mid-point interrupt at the period peak
// - duty update immediate or at boundary
// - override register forces individual outputs
// - special event compare produces trigger
// - per pair fault A enable bits
// - clear fault state drives pin inactive
// - cycle mode releases at next period
// - latched mode holds until software clears
module mpf_top
  import mpf_pkg::*;
#(
  parameter int W = 16
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fault_a_n,
  output logic [7:0] pwm_out,
  output logic special_trigger,
  output logic irq
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    mpf_cfg_t cfg;
    logic [NUM_PAIRS-1:0][W-1:0] duty_sw;
    logic [NUM_PAIRS-1:0][W-1:0] duty_act;
    logic [W-1:0] count;
    mpf_dir_t dir;
    logic done;
    logic fault_latched;
    logic [1:0] fault_sync;
    logic [NUM_EVENTS-1:0] status;
    logic [NUM_EVENTS-1:0] mask;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic [7:0] pwm;
    logic trig;
    logic irq;
  } mpf_state_t;

  mpf_state_t s_q;
  mpf_state_t s_d;
  // Raw outputs of the pair generators
  logic [7:0] pair_pins;
  // Synchronised fault level, active high
  logic fault_now;
  logic running;
  logic [7:0] flt_en_pins;
  logic [7:0] flt_force;
  logic period_end;
  logic center_zero;
  logic sevt_hit;
  logic [NUM_EVENTS-1:0] events;
  logic [NUM_EVENTS-1:0] w1c;
  logic wr_acc;
  logic rd_acc;
  logic [15:0] flta_wr;

  assign fault_now = ~s_q.fault_sync[1];
  assign running = s_q.cfg.enable && !s_q.done;

  // ****************************************
  // Pair generators
  // ****************************************
  // one generator per pair
  genvar g;
  generate
    for (g = 0; g < NUM_PAIRS; g++)
    begin : gen_pair
      mpf_pair #(.W(W)) u_pair (
        .count(s_q.count),
        .duty(s_q.duty_act[g]),
        .running(running),
        .compl_en(s_q.cfg.compl_en[g]),
        .ovr_en(s_q.cfg.ovr_en[2*g+1 -: 2]),
        .ovr_val(s_q.cfg.ovr_val[2*g+1 -: 2]),
        .pins(pair_pins[2*g+1 -: 2])
      );
      assign flt_en_pins[2*g+1 -: 2] = {2{s_q.cfg.flta[g]}};
    end
  endgenerate

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb
  begin
    s_d = s_q;
    // Second stage reads first only
    s_d.fault_sync = {s_q.fault_sync[0], fault_a_n};

    // Time base: edge counts up and wraps, center counts up/down
    period_end = 1'b0;
    center_zero = 1'b0;
    if (running)
    begin
      if (!s_q.cfg.center)
      begin
        if (s_q.count >= s_q.cfg.period)
        begin
          s_d.count = '0;
          period_end = 1'b1;
        end
        else
        begin
          s_d.count = s_q.count + 1'b1;
        end
      end
      else if (s_q.dir == MPF_UP)
      begin
        if (s_q.count >= s_q.cfg.period)
        begin
          s_d.dir = MPF_DOWN;
          s_d.count = s_q.count - 1'b1;
          center_zero = 1'b1;
        end
        else
        begin
          s_d.count = s_q.count + 1'b1;
        end
      end
      else if (s_q.count == '0)
      begin
        s_d.dir = MPF_UP;
        period_end = 1'b1;
      end
      else
      begin
        s_d.count = s_q.count - 1'b1;
      end
      // single pulse stops at period end
      if (period_end && s_q.cfg.single)
      begin
        s_d.done = 1'b1;
        s_d.count = '0;
      end
    end
    else if (!s_q.cfg.enable)
    begin
      s_d.count = '0;
      s_d.dir = MPF_UP;
      s_d.done = 1'b0;
    end

    if (s_q.cfg.immediate || period_end || center_zero || !running)
    begin
      s_d.duty_act = s_q.duty_sw;
    end

    sevt_hit = running && (s_q.count == s_q.cfg.sevt_cmp);
    s_d.trig = sevt_hit;

    if (fault_now && (s_q.cfg.flta[3:0] != '0))
    begin
      s_d.fault_latched = 1'b1;
    end
    // cycle mode releases at period end
    else if (s_q.cfg.flta[FLT_CYCLE_BIT] && period_end)
    begin
      s_d.fault_latched = 1'b0;
    end

    // Events and sticky status, set wins over clear
    events = '0;
    events[STAT_PERIOD] = period_end;
    events[STAT_SEVT] = sevt_hit;
    events[STAT_CZERO] = center_zero;
    events[STAT_FAULT] = fault_now && !s_q.fault_latched;
    wr_acc = psel && penable && pwrite && s_q.ready;
    rd_acc = psel && !penable && !pwrite;
    w1c = '0;
    if (wr_acc && paddr == ADDR_STAT)
    begin
      w1c = pwdata[NUM_EVENTS-1:0];
    end
    s_d.status = (s_q.status & ~w1c) | events;
    s_d.irq = |(s_d.status & s_q.mask);

    // APB slave: ready in access phase, one wait-free cycle
    s_d.ready = psel && !penable;
    s_d.slverr = 1'b0;
    // Refusal decided in setup so that it stands beside pready
    if (psel && !penable)
    begin
      unique case (paddr)
        ADDR_CTRL, ADDR_PERIOD, ADDR_DUTY1, ADDR_DUTY2, ADDR_DUTY3, ADDR_DUTY4,
        ADDR_SEVT, ADDR_OVR, ADDR_FLTA, ADDR_STAT, ADDR_MASK, ADDR_TBASE:
        begin
          s_d.slverr = 1'b0;
        end
        default: s_d.slverr = 1'b1;
      endcase
    end
    flta_wr = pwdata[15:0] & FLTA_IMPL_MASK;
    if (wr_acc)
    begin
      unique case (paddr)
        ADDR_CTRL:
        begin
          s_d.cfg.enable = pwdata[CTRL_EN];
          s_d.cfg.center = pwdata[CTRL_CENTER];
          s_d.cfg.single = pwdata[CTRL_SINGLE];
          s_d.cfg.immediate = pwdata[CTRL_IMMED];
          s_d.cfg.compl_en = pwdata[CTRL_COMPL_LO +: NUM_PAIRS];
          s_d.done = 1'b0;
        end
        ADDR_PERIOD: s_d.cfg.period = pwdata[W-1:0];
        ADDR_DUTY1: s_d.duty_sw[0] = pwdata[W-1:0];
        ADDR_DUTY2: s_d.duty_sw[1] = pwdata[W-1:0];
        ADDR_DUTY3: s_d.duty_sw[2] = pwdata[W-1:0];
        ADDR_DUTY4: s_d.duty_sw[3] = pwdata[W-1:0];
        ADDR_SEVT: s_d.cfg.sevt_cmp = pwdata[W-1:0];
        ADDR_OVR:
        begin
          s_d.cfg.ovr_en = pwdata[15:8];
          s_d.cfg.ovr_val = pwdata[7:0];
        end
        ADDR_FLTA:
        begin
          s_d.cfg.flta = flta_wr;
          // Writing the register clears a latched fault once the input is inactive
          if (!fault_now)
          begin
            s_d.fault_latched = 1'b0;
          end
        end
        ADDR_MASK: s_d.mask = pwdata[NUM_EVENTS-1:0];
        // Status clears above; count and unmapped words ignore writes
        default: s_d.slverr = 1'b0;
      endcase
    end
    else if (psel && penable && s_q.ready)
    begin
      s_d.slverr = 1'b0;
    end

    // Read data captured in setup phase
    if (rd_acc)
    begin
      s_d.rdata = RST_ZERO;
      unique case (paddr)
        ADDR_CTRL:
        begin
          s_d.rdata[CTRL_EN] = s_q.cfg.enable;
          s_d.rdata[CTRL_CENTER] = s_q.cfg.center;
          s_d.rdata[CTRL_SINGLE] = s_q.cfg.single;
          s_d.rdata[CTRL_IMMED] = s_q.cfg.immediate;
          s_d.rdata[CTRL_COMPL_LO +: NUM_PAIRS] = s_q.cfg.compl_en;
        end
        ADDR_PERIOD: s_d.rdata[W-1:0] = s_q.cfg.period;
        ADDR_DUTY1: s_d.rdata[W-1:0] = s_q.duty_sw[0];
        ADDR_DUTY2: s_d.rdata[W-1:0] = s_q.duty_sw[1];
        ADDR_DUTY3: s_d.rdata[W-1:0] = s_q.duty_sw[2];
        ADDR_DUTY4: s_d.rdata[W-1:0] = s_q.duty_sw[3];
        ADDR_SEVT: s_d.rdata[W-1:0] = s_q.cfg.sevt_cmp;
        ADDR_OVR: s_d.rdata[15:0] = {s_q.cfg.ovr_en, s_q.cfg.ovr_val};
        ADDR_FLTA: s_d.rdata[15:0] = s_q.cfg.flta;
        ADDR_STAT: s_d.rdata[NUM_EVENTS-1:0] = s_q.status;
        ADDR_MASK: s_d.rdata[NUM_EVENTS-1:0] = s_q.mask;
        ADDR_TBASE: s_d.rdata[W-1:0] = s_q.count;
        default: s_d.rdata = RST_ZERO;
      endcase
    end

    // Fault override of enabled pairs
    // clear state bit drives inactive
    flt_force = flt_en_pins & {8{s_q.fault_latched || fault_now}};
    s_d.pwm = (pair_pins & ~flt_force)
      | (s_q.cfg.flta[FLT_STATE_LO +: 8] & flt_force);
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= '0;
      s_q.fault_sync <= 2'h3;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign prdata = s_q.rdata;
  assign pready = s_q.ready;
  assign pslverr = s_q.slverr;
  assign pwm_out = s_q.pwm;
  assign special_trigger = s_q.trig;
  assign irq = s_q.irq;
endmodule
`default_nettype wire

// file: testbench/mpf_props.sv
`default_nettype none
module mpf_props
  import mpf_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic fault_a_n,
  input wire logic [7:0] pwm_out,
  input wire logic special_trigger,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Shadow of fault A control
  // ****
  logic [15:0] flt_q;
  logic [7:0] fmask;
  logic acc;
  // Completed access
  assign acc = psel && penable && pready && !pslverr;
  // Follows software writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flt_q <= 16'h0000;
    end
    else if (acc && pwrite && paddr == ADDR_FLTA)
    begin
      flt_q <= pwdata[15:0] & 16'hff8f;
    end
  end
  // Pins of enabled pairs
  always_comb
  begin
    for (int k = 0; k < 4; k++)
    begin
      fmask[2*k+:2] = {2{flt_q[k]}};
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_RDY_NEXT: assert property (psel && !penable |=> pready)
    else $error("no ready in access");
  AST_RDY_ONE: assert property (pready |=> !pready)
    else $error("ready too long");
  AST_ERR_RDY: assert property (pslverr |-> pready && psel && penable)
    else $error("stray slave error");
  AST_UNMAP: assert property (psel && penable && paddr > 8'h2c |-> pslverr)
    else $error("unmapped not refused");
  AST_BAD_RD: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  AST_FLT_RD: assert property (acc && !pwrite && paddr == ADDR_FLTA |->
    prdata == {16'h0000, flt_q}) else $error("fault ctrl readback");
  AST_FLT_PINS: assert property ((!fault_a_n)[*4] |->
    ((pwm_out ^ flt_q[15:8]) & fmask) == 8'h00) else $error("fault state");
  AST_RST_OUT: assert property ($rose(presetn) |-> pwm_out == 8'h00 && !irq)
    else $error("outputs after reset");
endmodule
bind mpf_top mpf_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .fault_a_n, .pwm_out, .special_trigger, .irq);
`default_nettype wire

// file: testbench/mpf_stage.sv
`default_nettype none
// Power stage: fault sense is active low, pulled up when quiet
module mpf_stage
(
  input wire logic pclk,
  input wire logic trip,
  input wire logic [7:0] pwm_out,
  output logic fault_a_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // Sense line follows the trip request
  assign fault_a_n = !trip;
endmodule
`default_nettype wire

// file: testbench/mpf_top_tb.sv
`default_nettype none
module mpf_top_tb
  import mpf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, trip, e;
  logic [7:0] paddr, pwm_out;
  logic [31:0] pwdata, prdata, v;
  logic pready, pslverr, fault_a_n, special_trigger, irq;
  int n_errors = 0;
  int checks_done = 0;
  mpf_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .fault_a_n, .pwm_out, .special_trigger, .irq);
  mpf_stage u_stage (.pclk, .trip, .pwm_out, .fault_a_n);
  // Clock
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Compare one value
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    checks_done++;
    if (g !== x)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, x, g);
    end
  endtask
  // One APB transfer, result in v and e
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the watchdog ends a wait that never answers
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    v = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Wait on settled outputs
  task automatic idle(input int n);
    repeat (n) @(negedge pclk);
  endtask
  // Register access kinds
  task automatic t_regs();
    apb(1'b0, ADDR_FLTA, 32'h0);
    chk("flta_rst", 32'h0, v);
    apb(1'b1, ADDR_FLTA, 32'hffff);
    apb(1'b0, ADDR_FLTA, 32'h0);
    chk("flta_rw", 32'hff8f, v);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h1, 32'(e));
    apb(1'b1, ADDR_FLTA, 32'h0);
    $display("regs done");
  endtask
  // Sixteen bit duty per pair, complementary lows
  task automatic t_duty();
    logic [15:0] dut [4] = '{16'h0100, 16'h0003, 16'h0080, 16'h0104};
    int hi [4] = '{0, 0, 0, 0};
    int bad = 0;
    apb(1'b1, ADDR_PERIOD, 32'h0104);
    for (int k = 0; k < 4; k++) apb(1'b1, ADDR_DUTY1 + 8'(4 * k), 32'(dut[k]));
    apb(1'b1, ADDR_CTRL, 32'hf1);
    idle(5);
    repeat (261)
    begin
      @(negedge pclk);
      for (int k = 0; k < 4; k++)
      begin
        hi[k] += int'(pwm_out[2*k+1]);
        bad += int'(pwm_out[2*k] === pwm_out[2*k+1]);
      end
    end
    for (int k = 0; k < 4; k++) chk("duty", 32'(dut[k]), 32'(hi[k]));
    chk("compl", 32'h0, 32'(bad));
    $display("duty done");
  endtask
  // Center mode event, trigger, mask and clear
  task automatic t_irq();
    int s = 0;
    apb(1'b1, ADDR_CTRL, 32'h0);
    apb(1'b1, ADDR_PERIOD, 32'h9);
    apb(1'b1, ADDR_SEVT, 32'h5);
    apb(1'b1, ADDR_MASK, 32'h4);
    apb(1'b1, ADDR_CTRL, 32'h3);
    for (int n = 0; n < 60 && irq !== 1'b1; n++)
    begin
      @(negedge pclk);
      s |= int'(special_trigger === 1'b1);
    end
    chk("trigger", 32'h1, 32'(s));
    chk("irq_mid", 32'h1, 32'(irq));
    apb(1'b1, ADDR_CTRL, 32'h0);
    apb(1'b1, ADDR_MASK, 32'h0);
    idle(2);
    chk("irq_mask", 32'h0, 32'(irq));
    apb(1'b1, ADDR_MASK, 32'h4);
    idle(2);
    chk("irq_held", 32'h1, 32'(irq));
    apb(1'b1, ADDR_STAT, 32'h4);
    idle(2);
    chk("irq_clr", 32'h0, 32'(irq));
    $display("irq done");
  endtask
  // Fault hit, hold, release; then software clear
  task automatic t_fault(input logic [31:0] f, input logic [7:0] after);
    apb(1'b1, ADDR_FLTA, f);
    @(posedge pclk);
    trip <= 1'b1;
    idle(5);
    chk("fault_on", 32'h06, 32'(pwm_out));
    @(posedge pclk);
    trip <= 1'b0;
    idle(25);
    chk("fault_off", 32'(after), 32'(pwm_out));
    apb(1'b1, ADDR_FLTA, f);
    idle(25);
    chk("fault_clr", 32'h0, 32'(pwm_out));
    $display("fault done");
  endtask
  // Single pulse: one burst of duty counts, then the time base rests
  task automatic t_single();
    int hi = 0;
    apb(1'b1, ADDR_CTRL, 32'h0);
    apb(1'b1, ADDR_PERIOD, 32'h9);
    apb(1'b1, ADDR_DUTY1, 32'h4);
    apb(1'b1, ADDR_CTRL, 32'h5);
    repeat (40)
    begin
      @(negedge pclk);
      hi += int'(pwm_out[1]);
    end
    chk("single", 32'h4, 32'(hi));
    apb(1'b0, ADDR_TBASE, 32'h0);
    chk("single_stop", 32'h0, v);
    apb(1'b1, ADDR_CTRL, 32'h0);
    $display("single done");
  endtask
  // Duty load held to the boundary, then taken at once
  task automatic t_immed();
    apb(1'b1, ADDR_DUTY1, 32'h0);
    apb(1'b1, ADDR_PERIOD, 32'hfff);
    apb(1'b1, ADDR_CTRL, 32'h1);
    apb(1'b1, ADDR_DUTY1, 32'hfff);
    idle(5);
    chk("duty_held", 32'h0, 32'(pwm_out[1]));
    apb(1'b1, ADDR_CTRL, 32'h9);
    idle(5);
    chk("duty_now", 32'h1, 32'(pwm_out[1]));
    apb(1'b1, ADDR_CTRL, 32'h0);
    $display("immediate done");
  endtask
  // Verdict
  task automatic complete_run();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    complete_run();
  end
  // Main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, trip} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_duty();
    t_irq();
    for (int k = 0; k < 4; k++) apb(1'b1, ADDR_DUTY1 + 8'(4 * k), 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h1);
    t_fault(32'h9603, 8'h06);
    t_fault(32'h9683, 8'h00);
    t_single();
    t_immed();
    apb(1'b1, ADDR_OVR, 32'h0c08);
    idle(3);
    chk("override", 32'h08, 32'(pwm_out));
    complete_run();
  end
endmodule
`default_nettype wire
